// >>> logic/tap_regs.vh
// Overview of operation
// - a sixteen-state test access controller stepped by the mode select input
// - mode select sampled on test clock rising edges; undriven pin reads high
// - serial data input sampled on rising test clock; undriven pin reads one
// - serial output driven only in shift states, changing on falling test clock
// - instruction register is three bits wide with no parity bit
// - decoded instruction changes only in update-ir or test-logic-reset, never while shifting
// - test-logic-reset sets instruction to all ones, which is bypass
// - capture-ir loads the fixed pattern 001 into the instruction stages
// - instruction bits shift in least significant bit first
// - decode: 000 extest, 001 highz, 010 sample, 100 clamp, all other codes (011, 101, 110, 111) bypass
// - extest selects boundary register and holds system logic in reset
// - highz resets system logic, selects bypass, floats all outputs
// - five rising edges with mode select high reach test-logic-reset
// - sample captures pins in capture-dr and shifts them out in shift-dr
// - update-dr loads boundary output latches for later extest or clamp
// - clamp drives pins from boundary latches, bypass forms the serial path
// - bypass links serial input to output through one register stage
// - capture-dr with bypass selected loads zero into the bypass stage
// - boundary register chains all pins, used by extest and sample
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// =====================================================
// instruction codes
`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_HIGHZ 3'h1
`define IR_SAMPLE 3'h2
`define IR_CLAMP 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1
`define IR_RESET 3'h7

// =====================================================
// boundary chain size
`define BSR_PINS 8
`define BSR_LEN 16

`endif

// >>> logic/bsr_chain.v
`timescale 1ns/1ns
`include "tap_regs.vh"

// =====================================================
// boundary register: shift stages plus update latches
module bsr_chain (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_tlr,
  input wire i_capture,
  input wire i_shift,
  input wire i_update,
  input wire i_tdi,
  input wire [`BSR_LEN-1:0] i_pins,
  output wire o_sout,
  output reg [`BSR_LEN-1:0] o_latch
);
  reg [`BSR_LEN-1:0] stage;

  assign o_sout = stage[0];

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage <= {`BSR_LEN{1'b0}};
      o_latch <= {`BSR_LEN{1'b0}};
    end else begin
      if (i_capture) begin
        stage <= i_pins;
      end else if (i_shift) begin
        stage <= {i_tdi, stage[`BSR_LEN-1:1]};
      end
      if (i_tlr) begin
        o_latch <= {`BSR_LEN{1'b0}};
      end else if (i_update) begin
        o_latch <= stage;
      end
    end
  end
endmodule // bsr_chain

// >>> logic/tap_port.v
`timescale 1ns/1ns
`include "tap_regs.vh"

// =====================================================
// test access port, sampled on the core clock
module tap_port (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire [`BSR_PINS-1:0] i_sys_out,
  input wire [`BSR_PINS-1:0] i_sys_oe,
  input wire [`BSR_PINS-1:0] i_pin_in,
  output reg o_tdo,
  output reg o_tdo_oe,
  output reg [`BSR_PINS-1:0] o_pin_out,
  output reg [`BSR_PINS-1:0] o_pin_oe,
  output reg [`BSR_PINS-1:0] o_core_in,
  output reg o_sys_reset,
  output reg [`IR_WIDTH-1:0] o_instr
);
  // =====================================================
  // tap states, one-hot
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PA_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UP_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PA_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UP_IR = 16'h8000;

  // =====================================================
  // three-stage pin sampling
  // pins are from outside this clock domain; a level counts once stages 2 and 3 agree
  reg [2:0] tck_s;
  reg [2:0] tms_s;
  reg [2:0] tdi_s;
  reg tck_q;
  reg tms_q;
  reg tdi_q;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tck_s <= 3'h0;
      tms_s <= 3'h7;
      tdi_s <= 3'h7;
      tck_q <= 1'b0;
      tms_q <= 1'b1;
      tdi_q <= 1'b1;
    end else begin
      tck_s <= {tck_s[1:0], i_tck};
      tms_s <= {tms_s[1:0], i_tms};
      tdi_s <= {tdi_s[1:0], i_tdi};
      if (tck_s[1] == tck_s[2]) begin
        tck_q <= tck_s[2];
      end
      if (tms_s[1] == tms_s[2]) begin
        tms_q <= tms_s[2];
      end
      if (tdi_s[1] == tdi_s[2]) begin
        tdi_q <= tdi_s[2];
      end
    end
  end

  wire tck_rise;
  wire tck_fall;
  assign tck_rise = (tck_s[1] == tck_s[2]) && tck_s[2] && !tck_q;
  assign tck_fall = (tck_s[1] == tck_s[2]) && !tck_s[2] && tck_q;

  // =====================================================
  // controller
  reg [15:0] state;
  reg [15:0] next_state;

  always @* begin
    case (state)
      S_TLR: next_state = tms_q ? S_TLR : S_RTI;
      S_RTI: next_state = tms_q ? S_SEL_DR : S_RTI;
      S_SEL_DR: next_state = tms_q ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_q ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = tms_q ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_q ? S_UP_DR : S_PA_DR;
      S_PA_DR: next_state = tms_q ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: next_state = tms_q ? S_UP_DR : S_SH_DR;
      S_UP_DR: next_state = tms_q ? S_SEL_DR : S_RTI;
      S_SEL_IR: next_state = tms_q ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = tms_q ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = tms_q ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_q ? S_UP_IR : S_PA_IR;
      S_PA_IR: next_state = tms_q ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: next_state = tms_q ? S_UP_IR : S_SH_IR;
      S_UP_IR: next_state = tms_q ? S_SEL_DR : S_RTI;
      default: next_state = S_TLR;
    endcase
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  wire in_tlr;
  assign in_tlr = (state == S_TLR);

  // =====================================================
  // instruction decode
  wire sel_bsr;
  wire is_extest;
  wire is_highz;
  wire is_clamp;
  assign is_extest = (o_instr == `IR_EXTEST);
  assign is_highz = (o_instr == `IR_HIGHZ);
  assign is_clamp = (o_instr == `IR_CLAMP);
  // all other codes fall through to bypass
  assign sel_bsr = is_extest || (o_instr == `IR_SAMPLE);

  // =====================================================
  // instruction and bypass shift stages
  reg [`IR_WIDTH-1:0] ir_shift;
  reg bypass_bit;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ir_shift <= `IR_RESET;
      o_instr <= `IR_RESET;
      bypass_bit <= 1'b0;
    end else if (in_tlr) begin
      // held on every core cycle in tlr, so bypass is active one core cycle after tlr is entered
      ir_shift <= `IR_RESET;
      o_instr <= `IR_RESET;
    end else if (tck_rise) begin
      if (state == S_CAP_IR) begin
        ir_shift <= `IR_CAPTURE;
      end else if (state == S_SH_IR) begin
        ir_shift <= {tdi_q, ir_shift[`IR_WIDTH-1:1]};
      end else if (state == S_UP_IR) begin
        o_instr <= ir_shift;
      end
      if (state == S_CAP_DR && !sel_bsr) begin
        bypass_bit <= 1'b0;
      end else if (state == S_SH_DR) begin
        bypass_bit <= tdi_q;
      end
    end
  end

  // =====================================================
  // boundary chain: output data, then input pins
  wire [`BSR_LEN-1:0] bsr_latch;
  wire bsr_sout;
  wire [`BSR_LEN-1:0] cap_pins;
  assign cap_pins = {i_sys_out, i_pin_in};

  bsr_chain u_bsr (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_tlr(in_tlr),
    .i_capture(tck_rise && sel_bsr && state == S_CAP_DR),
    .i_shift(tck_rise && sel_bsr && state == S_SH_DR),
    .i_update(tck_rise && sel_bsr && state == S_UP_DR),
    .i_tdi(tdi_q),
    .i_pins(cap_pins),
    .o_sout(bsr_sout),
    .o_latch(bsr_latch)
  );

  // =====================================================
  // serial output on falling edge
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo_oe <= (state == S_SH_IR) || (state == S_SH_DR);
      if (state == S_SH_IR) begin
        o_tdo <= ir_shift[0];
      end else if (sel_bsr) begin
        o_tdo <= bsr_sout;
      end else begin
        o_tdo <= bypass_bit;
      end
    end
  end

  // =====================================================
  // pin muxing and system reset
  // the system reset is held through any extest/highz until a new instruction
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out <= {`BSR_PINS{1'b0}};
      o_pin_oe <= {`BSR_PINS{1'b0}};
      o_core_in <= {`BSR_PINS{1'b0}};
      o_sys_reset <= 1'b0;
    end else begin
      o_sys_reset <= is_extest || is_highz;
      o_core_in <= i_pin_in;
      if (is_highz) begin
        o_pin_out <= i_sys_out;
        o_pin_oe <= {`BSR_PINS{1'b0}};
      end else if (is_extest || is_clamp) begin
        // latches only move in update-dr with bsr selected or when cleared in tlr, so clamp holds pins steady
        o_pin_out <= bsr_latch[`BSR_LEN-1:`BSR_PINS];
        o_pin_oe <= 8'hff;
      end else begin
        o_pin_out <= i_sys_out;
        o_pin_oe <= i_sys_oe;
      end
    end
  end
endmodule // tap_port

// >>> tb/tap_port_sva.sv
`timescale 1ns/1ns
`include "tap_regs.vh"
// ====
// port checker
module tap_chk (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_tck,
  input wire i_tms,
  input wire [7:0] i_sys_out,
  input wire [7:0] i_sys_oe,
  input wire [7:0] i_pin_in,
  input wire o_tdo,
  input wire o_tdo_oe,
  input wire [7:0] o_pin_out,
  input wire [7:0] o_pin_oe,
  input wire [7:0] o_core_in,
  input wire o_sys_reset,
  input wire [2:0] o_instr
);
  reg [2:0] n1;
  // raw rises with select high, saturating to stay small
  always @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      n1 <= 3'h0;
    else if ($rose(i_tck))
      n1 <= !i_tms ? 3'h0 : n1 + (n1 != 3'h6);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_tlr;
    ##[0:6] o_instr == `IR_RESET;
  endsequence
  property p_tlr; n1 == 3'h5 |-> s_tlr; endproperty
  a_tlr: assert property (p_tlr) else $error("no reset state");
  property p_rst; o_sys_reset == ($past(o_instr) == `IR_EXTEST || $past(o_instr) == `IR_HIGHZ); endproperty
  a_rst: assert property (p_rst) else $error("system reset wrong");
  property p_float; $past(o_instr) == `IR_HIGHZ |-> o_pin_oe == 8'h00; endproperty
  a_float: assert property (p_float) else $error("pins not floated");
  property p_drive; $past(o_instr) inside {`IR_EXTEST, `IR_CLAMP} |-> o_pin_oe == 8'hff; endproperty
  a_drive: assert property (p_drive) else $error("pins not driven");
  property p_pass;
    $past(i_rstn) && $past(o_instr) inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7}
      |-> o_pin_out == $past(i_sys_out) && o_pin_oe == $past(i_sys_oe);
  endproperty
  a_pass: assert property (p_pass) else $error("pins disturbed");
  property p_hold; $past(o_instr, 2) == `IR_CLAMP && $past(o_instr) == `IR_CLAMP |-> $stable(o_pin_out); endproperty
  a_hold: assert property (p_hold) else $error("clamped pins moved");
  property p_core; $past(i_rstn) && $past(o_instr) == `IR_SAMPLE |-> o_core_in == $past(i_pin_in); endproperty
  a_core: assert property (p_core) else $error("core input disturbed");
  property p_still; $changed(o_instr) |-> !o_tdo_oe; endproperty
  a_still: assert property (p_still) else $error("instruction moved in shift");
  property p_fall; $changed({o_tdo, o_tdo_oe}) |-> !$past(i_tck, 2); endproperty
  a_fall: assert property (p_fall) else $error("output moved off fall");
endmodule // tap_chk
bind tap_port tap_chk i_chk (.i_core_clk, .i_rstn, .i_tck, .i_tms, .i_sys_out, .i_sys_oe, .i_pin_in,
  .o_tdo, .o_tdo_oe, .o_pin_out, .o_pin_oe, .o_core_in, .o_sys_reset, .o_instr);

// >>> tb/tap_tester.sv
`timescale 1ns/1ns
// ====
// board tester on the test pins
module tap_tester (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  // clock still between frames, lines at pull-up level
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // lines set half a period before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #400 o_tck = 1'b1;
    // own sync: read late in high phase, long after output settled
    #390 tdo = i_tdo_oe ? i_tdo : 1'bx;
    #10 o_tck = 1'b0;
  endtask
endmodule // tap_tester

// >>> tb/tb_tap_port.sv
`timescale 1ns/1ns
`include "tap_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t %h %h", $time, g, e); end end
// ====
// bench
module tb_tap_port;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_sys_reset;
  logic [7:0] i_sys_out = 8'h00;
  logic [7:0] i_sys_oe = 8'h00;
  logic [7:0] i_pin_in = 8'h00;
  logic [7:0] o_pin_out, o_pin_oe, o_core_in;
  logic [7:0] lat = 8'h00;
  logic [2:0] o_instr;
  logic [15:0] got, pre;
  logic [31:0] rs = 32'h954b;
  int n_mismatch = 0;
  int tests_run = 0;
  tap_port i_dut (.i_core_clk, .i_rstn, .i_tck, .i_tms, .i_tdi, .i_sys_out, .i_sys_oe, .i_pin_in,
    .o_tdo, .o_tdo_oe, .o_pin_out, .o_pin_oe, .o_core_in, .o_sys_reset, .o_instr);
  tap_tester i_tester (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [7:0] exp_oe(input int c);
    return (c == 1) ? 8'h00 : (c == 0 || c == 4) ? 8'hff : i_sys_oe;
  endfunction
  task automatic go(input logic m);
    logic d;
    i_tester.step(m, 1'b1, d);
  endtask
  task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic d;
    dout = 16'h0;
    go(1'b1);
    if (ir) go(1'b1);
    go(1'b0);
    go(1'b0);
    for (int i = 0; i < n; i++) begin
      i_tester.step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    go(1'b1);
    go(1'b0);
    // pins and system reset follow the new instruction one core cycle later
    repeat (2) @(posedge i_core_clk);
    #13;
  endtask
  task automatic new_pins();
    logic [31:0] r;
    r = rnd();
    @(posedge i_core_clk);
    i_sys_out <= r[7:0];
    i_sys_oe <= r[15:8];
    i_pin_in <= r[23:16];
    #13;
  endtask
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #50 i_core_clk = ~i_core_clk;
  initial begin
    repeat (60000) @(posedge i_core_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    #13;
    `CHK(o_instr, `IR_RESET)
    go(1'b0);
    for (int c = 0; c < 8; c++) begin
      new_pins();
      scan(1'b1, 3, 16'(c), got);
      `CHK(got[2:0], `IR_CAPTURE)
      `CHK(o_instr, c[2:0])
      `CHK(o_sys_reset, c < 2)
      `CHK(o_pin_oe, exp_oe(c))
      if (c != 1) `CHK(o_pin_out, (c == 0 || c == 4) ? lat : i_sys_out)
      `CHK(o_core_in, i_pin_in)
      pre = 16'(rnd());
      scan(1'b0, 16, pre, got);
      if (c == 0 || c == 2) begin
        `CHK(got, {i_sys_out, i_pin_in})
        lat = pre[15:8];
      end else `CHK(got, {pre[14:0], 1'b0})
    end
    scan(1'b1, 3, 16'h0, got);
    go(1'b1);
    repeat (3) go(1'b0);
    `CHK(o_tdo_oe, 1'b1)
    repeat (5) go(1'b1);
    repeat (3) @(posedge i_core_clk);
    #13;
    `CHK(o_tdo_oe, 1'b0)
    `CHK(o_instr, `IR_RESET)
    `CHK(o_sys_reset, 1'b0)
    give_verdict();
  end
endmodule // tb_tap_port
